// >>> verilog/adc_control_register_bank.sv
/*
  Control register bank of a dual-channel converter: channel select, shadowed program registers,
  transfer command, power modes, clock divider, stabilizer, test patterns and self-test control.
  Assumes a serial port engine outside that presents whole-byte register reads and writes on ref_clk.
*/
// What this block does
// - The two-bit power mode field selects run, full power-down, standby or digital reset per channel.
// - The input clock is divided by the three-bit divider code plus one, codes 0 to 5, default zero.
// - Pattern codes 1 to 4 give midscale, positive and negative full scale and checkerboard; 0 is off.
// - Codes 5 and 6 give the long and short pseudorandom sequences, each with its own reset bit.
// - Code 7 toggles whole words, code 9 toggles alternate bits, code 10 gives mixed bit frequency.
// - Code 8 sends user patterns sequenced as single, alternate, single once or alternate once.
// - Channel-local writes go to channel A on select bit 0, B on bit 1, and both when both are set.
// - A read with both select bits set returns channel A's contents.
// - Writes to 0x08 through 0x18 stay in shadow storage until 0x01 is written to the transfer register.
// - The transfer bit clears itself once the shadowed values are applied.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_control_register_bank
  import adc_ctrl_pkg::*;
#(
  parameter int         W       = 16,
  parameter logic [7:0] CHIP_ID = 8'h5A  // arbitrary identification value
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          reg_wr_en,
  input  wire logic          reg_rd_en,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic [7:0]         reg_rdata,
  output logic               reg_rd_valid,
  output logic [1:0]         power_down,
  output logic [1:0]         standby,
  output logic [1:0]         digital_reset,
  output logic [1:0]         ext_pd_enable,
  output logic               dcs_enable,
  output logic [2:0]         clk_div_ratio,
  output logic               clk_div_tick,
  output logic               self_test_enable,
  output logic               self_test_init,
  output logic [1:0]         pattern_active,
  output logic [W-1:0]       pattern_data_a,
  output logic [W-1:0]       pattern_data_b
);

  // user pattern storage is 16 bits, so wider words are refused
  if (W < 9 || W > 16 || (W % 2) != 0) begin : g_bad_width
    $error("pattern width must be even and 9..16");
  end

  // ----------------------------------------------------------------
  // register state: shadow copies take writes, live copies steer logic
  // ----------------------------------------------------------------
  logic [7:0]   chan_sel;
  logic [7:0]   xfer;
  logic [7:0]   sh_mode   [2];
  logic [7:0]   sh_test   [2];
  logic [7:0]   sh_clock;
  logic [7:0]   sh_div;
  logic [7:0]   sh_built_in_self_test;
  logic [7:0]   lv_mode   [2];
  logic [7:0]   lv_test   [2];
  logic [7:0]   lv_clock;
  logic [7:0]   lv_div;
  logic [7:0]   lv_built_in_self_test;
  logic [15:0]  user_p1;
  logic [15:0]  user_p2;
  logic [7:0]   next_chan_sel;
  logic [7:0]   next_xfer;
  logic [7:0]   next_sh_mode [2];
  logic [7:0]   next_sh_test [2];
  logic [7:0]   next_sh_clock;
  logic [7:0]   next_sh_div;
  logic [7:0]   next_sh_built_in_self_test;
  logic [7:0]   next_lv_mode [2];
  logic [7:0]   next_lv_test [2];
  logic [7:0]   next_lv_clock;
  logic [7:0]   next_lv_div;
  logic [7:0]   next_lv_built_in_self_test;
  logic [15:0]  next_user_p1;
  logic [15:0]  next_user_p2;
  logic         applied;
  logic         next_applied;

  always_comb begin
    next_chan_sel = chan_sel;
    next_sh_mode  = sh_mode;
    next_sh_test  = sh_test;
    next_sh_clock = sh_clock;
    next_sh_div   = sh_div;
    next_sh_built_in_self_test  = sh_built_in_self_test;
    next_lv_mode  = lv_mode;
    next_lv_test  = lv_test;
    next_lv_clock = lv_clock;
    next_lv_div   = lv_div;
    next_lv_built_in_self_test  = lv_built_in_self_test;
    next_user_p1  = user_p1;
    next_user_p2  = user_p2;
    next_applied  = 1'b0;
    next_xfer     = xfer;
    // a pending transfer copies every shadow at once, then drops its bit
    if (xfer[`BIT_TRANSFER]) begin
      next_lv_mode  = sh_mode;
      next_lv_test  = sh_test;
      next_lv_clock = sh_clock;
      next_lv_div   = sh_div;
      next_lv_built_in_self_test  = sh_built_in_self_test;
      next_applied  = 1'b1;
      next_xfer     = `RST_SHADOW_UPDATE;
    end
    if (reg_wr_en) begin
      unique case (reg_addr)
        `OFS_CHANNEL_SEL:    next_chan_sel = {6'h00, reg_wdata[1:0]};
        `OFS_OPERATING_MODE: begin
          for (int c = 0; c < 2; c++) begin
            if (chan_sel[c]) next_sh_mode[c] = reg_wdata & 8'h83;
          end
        end
        `OFS_TEST_PATTERN: begin
          for (int c = 0; c < 2; c++) begin
            if (chan_sel[c]) next_sh_test[c] = reg_wdata;
          end
        end
        `OFS_CLOCK_COND:     next_sh_clock = reg_wdata & 8'h01;
        `OFS_CLOCK_DIVIDER:  next_sh_div   = reg_wdata & 8'h07;
        `OFS_SELF_TEST:      next_sh_built_in_self_test  = reg_wdata & 8'h05;
        `OFS_USER_P1_LSB:    next_user_p1[7:0]  = reg_wdata;
        `OFS_USER_P1_MSB:    next_user_p1[15:8] = reg_wdata;
        `OFS_USER_P2_LSB:    next_user_p2[7:0]  = reg_wdata;
        `OFS_USER_P2_MSB:    next_user_p2[15:8] = reg_wdata;
        // a new command that lands with the clear still takes effect
        `OFS_SHADOW_UPDATE:  next_xfer = reg_wdata & `TRANSFER_COMMAND;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chan_sel <= `RST_CHANNEL_SEL;
      xfer     <= `RST_SHADOW_UPDATE;
      for (int c = 0; c < 2; c++) begin
        sh_mode[c] <= `RST_OPERATING_MODE;
        sh_test[c] <= `RST_TEST_PATTERN;
        lv_mode[c] <= `RST_OPERATING_MODE;
        lv_test[c] <= `RST_TEST_PATTERN;
      end
      sh_clock <= `RST_CLOCK_COND;
      sh_div   <= `RST_CLOCK_DIVIDER;
      sh_built_in_self_test  <= `RST_SELF_TEST;
      lv_clock <= `RST_CLOCK_COND;
      lv_div   <= `RST_CLOCK_DIVIDER;
      lv_built_in_self_test  <= `RST_SELF_TEST;
      user_p1  <= {2{`RST_USER_PATTERN}};
      user_p2  <= {2{`RST_USER_PATTERN}};
      applied  <= 1'b0;
    end else begin
      chan_sel <= next_chan_sel;
      xfer     <= next_xfer;
      sh_mode  <= next_sh_mode;
      sh_test  <= next_sh_test;
      sh_clock <= next_sh_clock;
      sh_div   <= next_sh_div;
      sh_built_in_self_test  <= next_sh_built_in_self_test;
      lv_mode  <= next_lv_mode;
      lv_test  <= next_lv_test;
      lv_clock <= next_lv_clock;
      lv_div   <= next_lv_div;
      lv_built_in_self_test  <= next_lv_built_in_self_test;
      user_p1  <= next_user_p1;
      user_p2  <= next_user_p2;
      applied  <= next_applied;
    end
  end

  // ----------------------------------------------------------------
  // read port: shadow values are what software sees
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  int unsigned rd_ch;

  always_comb begin
    rd_ch = chan_sel[`BIT_SEL_CHAN_A] ? 0 : 1;
    unique case (reg_addr)
      `OFS_CHIP_ID:        next_rdata = CHIP_ID;
      `OFS_CHANNEL_SEL:    next_rdata = chan_sel;
      `OFS_OPERATING_MODE: next_rdata = sh_mode[rd_ch];
      `OFS_TEST_PATTERN:   next_rdata = sh_test[rd_ch];
      `OFS_CLOCK_COND:     next_rdata = sh_clock;
      `OFS_CLOCK_DIVIDER:  next_rdata = sh_div;
      `OFS_SELF_TEST:      next_rdata = sh_built_in_self_test;
      `OFS_USER_P1_LSB:    next_rdata = user_p1[7:0];
      `OFS_USER_P1_MSB:    next_rdata = user_p1[15:8];
      `OFS_USER_P2_LSB:    next_rdata = user_p2[7:0];
      `OFS_USER_P2_MSB:    next_rdata = user_p2[15:8];
      `OFS_SHADOW_UPDATE:  next_rdata = xfer;
      default:             next_rdata = 8'h00;
    endcase
    if (!reg_rd_en) next_rdata = reg_rdata;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rdata    <= next_rdata;
      reg_rd_valid <= reg_rd_en;
    end
  end

  // ----------------------------------------------------------------
  // input clock divider; codes above 5 clamp to divide by 6
  // ----------------------------------------------------------------
  logic [2:0] div_code;
  logic [2:0] div_cnt;
  logic [2:0] next_div_cnt;
  logic       next_tick;

  always_comb begin
    div_code = (lv_div[2:0] > `DIVIDER_MAX_CODE) ? `DIVIDER_MAX_CODE : lv_div[2:0];
    next_tick    = (div_cnt >= div_code);
    next_div_cnt = next_tick ? 3'h0 : div_cnt + 3'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt      <= 3'h0;
      clk_div_tick <= 1'b0;
    end else begin
      div_cnt      <= next_div_cnt;
      clk_div_tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // live control outputs
  // ----------------------------------------------------------------
  assign clk_div_ratio    = div_code;
  assign dcs_enable       = lv_clock[`BIT_DUTY_STABILIZE];
  assign self_test_enable = lv_built_in_self_test[`BIT_SELF_TEST_ENABLE];
  assign self_test_init   = lv_built_in_self_test[`BIT_SELF_TEST_INIT];

  logic [W-1:0] pat_data [2];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    power_mode_e pm;
    pattern_cfg_if #(.W(W)) cfg ();
    assign pm               = power_mode_e'(lv_mode[c][`POWER_MODE_MSB:`POWER_MODE_LSB]);
    assign power_down[c]    = (pm == PWR_DOWN);
    assign standby[c]       = (pm == PWR_STANDBY);
    assign digital_reset[c] = (pm == PWR_DIGITAL_RST);
    assign ext_pd_enable[c] = lv_mode[c][`BIT_EXT_PD_ENABLE];
    assign cfg.mode         = lv_test[c][`PATTERN_MSB:`PATTERN_LSB];
    assign cfg.user_seq     = lv_test[c][`USER_SEQ_MSB:`USER_SEQ_LSB];
    assign cfg.long_pn_rst  = lv_test[c][`BIT_RESET_LONG_PN];
    assign cfg.short_pn_rst = lv_test[c][`BIT_RESET_SHORT_PN];
    // a powered channel only advances in run mode; digital reset also clears it
    assign cfg.hold_rst     = (pm == PWR_DIGITAL_RST);
    assign cfg.tick         = clk_div_tick && (pm == PWR_RUN);
    assign cfg.restart      = applied;
    assign cfg.user_p1      = user_p1[W-1:0];
    assign cfg.user_p2      = user_p2[W-1:0];
    pattern_gen #(.W(W)) u_gen (
      .ref_clk (ref_clk),
      .rst     (rst),
      .cfg     (cfg.gen),
      .data    (pat_data[c]),
      .active  (pattern_active[c])
    );
  end

  assign pattern_data_a = pat_data[0];
  assign pattern_data_b = pat_data[1];

endmodule

// >>> verilog/adc_ctrl_defines.svh
/*
  Register offsets, field positions, reset values and fixed codes of the converter control bank.
  Assumes inclusion by bare name from any file that needs the register map.
*/
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CHIP_ID            8'h01
`define OFS_CHANNEL_SEL        8'h05
`define OFS_OPERATING_MODE     8'h08
`define OFS_CLOCK_COND         8'h09
`define OFS_CLOCK_DIVIDER      8'h0B
`define OFS_TEST_PATTERN       8'h0D
`define OFS_SELF_TEST          8'h0E
`define OFS_USER_P1_LSB        8'h19
`define OFS_USER_P1_MSB        8'h1A
`define OFS_USER_P2_LSB        8'h1B
`define OFS_USER_P2_MSB        8'h1C
`define OFS_SHADOW_UPDATE      8'hFF
`define OFS_SHADOW_FIRST       8'h08
`define OFS_SHADOW_LAST        8'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CHANNEL_SEL        8'h03
`define RST_OPERATING_MODE     8'h80
`define RST_CLOCK_COND         8'h00
`define RST_CLOCK_DIVIDER      8'h00
`define RST_TEST_PATTERN       8'h00
`define RST_SELF_TEST          8'h00
`define RST_SHADOW_UPDATE      8'h00
`define RST_USER_PATTERN       8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_SEL_CHAN_A         0
`define BIT_SEL_CHAN_B         1
`define BIT_EXT_PD_ENABLE      7
`define POWER_MODE_MSB         1
`define POWER_MODE_LSB         0
`define BIT_DUTY_STABILIZE     0
`define DIVIDER_MSB            2
`define DIVIDER_LSB            0
`define PATTERN_MSB            3
`define PATTERN_LSB            0
`define BIT_RESET_SHORT_PN     4
`define BIT_RESET_LONG_PN      5
`define USER_SEQ_MSB           7
`define USER_SEQ_LSB           6
`define BIT_SELF_TEST_ENABLE   0
`define BIT_SELF_TEST_INIT     2
`define BIT_TRANSFER           0

// ----------------------------------------------------------------
// fixed codes
// ----------------------------------------------------------------
`define DIVIDER_MAX_CODE       3'h5
`define TRANSFER_COMMAND       8'h01

`endif

// >>> verilog/adc_ctrl_pkg.sv
/*
  Types shared by the control bank and its pattern generator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    PWR_RUN        = 2'h0,
    PWR_DOWN       = 2'h1,
    PWR_STANDBY    = 2'h2,
    PWR_DIGITAL_RST = 2'h3
  } power_mode_e;

  typedef enum logic [3:0] {
    PAT_OFF          = 4'h0,
    PAT_MIDSCALE     = 4'h1,
    PAT_POS_FULL     = 4'h2,
    PAT_NEG_FULL     = 4'h3,
    PAT_CHECKER      = 4'h4,
    PAT_LONG_PN      = 4'h5,
    PAT_SHORT_PN     = 4'h6,
    PAT_WORD_TOGGLE  = 4'h7,
    PAT_USER         = 4'h8,
    PAT_BIT_TOGGLE   = 4'h9,
    PAT_MIXED_FREQ   = 4'hA
  } pattern_e;

  typedef enum logic [1:0] {
    SEQ_SINGLE         = 2'h0,
    SEQ_ALTERNATE      = 2'h1,
    SEQ_SINGLE_ONCE    = 2'h2,
    SEQ_ALTERNATE_ONCE = 2'h3
  } user_seq_e;

  typedef enum logic [2:0] {
    US_FIRST  = 3'b001,
    US_SECOND = 3'b010,
    US_DONE   = 3'b100
  } user_state_e;

endpackage

// >>> verilog/pattern_cfg_if.sv
/*
  Carrier for one channel's active pattern settings, from the register bank to its generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface pattern_cfg_if #(parameter int W = 16);
  import adc_ctrl_pkg::*;
  logic [3:0]   mode;
  logic [1:0]   user_seq;
  logic         long_pn_rst;
  logic         short_pn_rst;
  logic         hold_rst;
  logic         restart;
  logic         tick;
  logic [W-1:0] user_p1;
  logic [W-1:0] user_p2;

  modport ctrl (output mode, user_seq, long_pn_rst, short_pn_rst, hold_rst, restart, tick, user_p1, user_p2);
  modport gen  (input  mode, user_seq, long_pn_rst, short_pn_rst, hold_rst, restart, tick, user_p1, user_p2);
endinterface

// >>> verilog/pattern_gen.sv
/*
  Per-channel digital test pattern source, one word per sample tick.
  Assumes settings arrive already transferred from shadow storage.
*/
`timescale 1ns/1ps

module pattern_gen
  import adc_ctrl_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic      ref_clk,
  input  wire logic      rst,
  pattern_cfg_if.gen     cfg,
  output logic [W-1:0]   data,
  output logic           active
);

  localparam logic [W-1:0] ODD_BITS  = {(W/2){2'b10}};
  localparam logic [W-1:0] EVEN_BITS = {(W/2){2'b01}};
  localparam logic [W-1:0] MIDSCALE  = {1'b1, {(W-1){1'b0}}};

  // widths the generators cannot fill are refused at elaboration
  if (W < 2 || W > 23 || (W % 2) != 0) begin : g_bad_width
    $error("pattern width must be even and 2..23");
  end

  logic [22:0]  long_pn;
  logic [8:0]   short_pn;
  logic         phase;
  logic [W-1:0] mix_cnt;
  user_state_e  ustate;
  logic [22:0]  next_long_pn;
  logic [8:0]   next_short_pn;
  logic         next_phase;
  logic [W-1:0] next_mix_cnt;
  user_state_e  next_ustate;
  logic [W-1:0] next_data;
  logic         next_active;
  logic [W-1:0] short_word;

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  always_comb begin
    next_long_pn  = long_pn;
    next_short_pn = short_pn;
    next_phase    = phase;
    next_mix_cnt  = mix_cnt;
    next_ustate   = ustate;
    if (cfg.tick) begin
      next_long_pn  = {long_pn[21:0], long_pn[22] ^ long_pn[17]};
      next_short_pn = {short_pn[7:0], short_pn[8] ^ short_pn[4]};
      next_phase    = ~phase;
      next_mix_cnt  = mix_cnt + {{(W-1){1'b0}}, 1'b1};
      unique case (ustate)
        US_FIRST: begin
          unique case (user_seq_e'(cfg.user_seq))
            SEQ_SINGLE:         next_ustate = US_FIRST;
            SEQ_SINGLE_ONCE:    next_ustate = US_DONE;
            SEQ_ALTERNATE,
            SEQ_ALTERNATE_ONCE: next_ustate = US_SECOND;
          endcase
        end
        US_SECOND: begin
          next_ustate = (cfg.user_seq == SEQ_ALTERNATE) ? US_FIRST : US_DONE;
        end
        US_DONE:   next_ustate = US_DONE;
        default:   next_ustate = US_FIRST;
      endcase
    end
    // each generator restarts from its own seed
    if (cfg.long_pn_rst || cfg.hold_rst) begin
      next_long_pn = '1;
    end
    if (cfg.short_pn_rst || cfg.hold_rst) begin
      next_short_pn = '1;
    end
    if (cfg.restart || cfg.hold_rst) begin
      next_phase   = 1'b0;
      next_mix_cnt = '0;
      next_ustate  = US_FIRST;
    end
  end

  // ----------------------------------------------------------------
  // word selection
  // ----------------------------------------------------------------
  always_comb begin
    short_word = '0;
    for (int i = 0; i < W; i++) begin
      short_word[i] = short_pn[i % 9];
    end
    next_active = 1'b1;
    unique case (cfg.mode)
      PAT_MIDSCALE:    next_data = MIDSCALE;
      PAT_POS_FULL:    next_data = '1;
      PAT_NEG_FULL:    next_data = '0;
      PAT_CHECKER:     next_data = phase ? ODD_BITS : EVEN_BITS;
      PAT_LONG_PN:     next_data = long_pn[W-1:0];
      PAT_SHORT_PN:    next_data = short_word;
      PAT_WORD_TOGGLE: next_data = phase ? '1 : '0;
      PAT_BIT_TOGGLE:  next_data = phase ? ODD_BITS : '0;
      PAT_MIXED_FREQ:  next_data = mix_cnt;
      PAT_USER: begin
        next_data = (ustate == US_FIRST) ? cfg.user_p1 : (ustate == US_SECOND) ? cfg.user_p2 : '0;
      end
      default: begin
        // off and unused codes drive a zero word and clear active
        next_data   = '0;
        next_active = 1'b0;
      end
    endcase
    if (cfg.hold_rst) begin
      next_data   = '0;
      next_active = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      long_pn  <= '1;
      short_pn <= '1;
      phase    <= 1'b0;
      mix_cnt  <= '0;
      ustate   <= US_FIRST;
      data     <= '0;
      active   <= 1'b0;
    end else begin
      long_pn  <= next_long_pn;
      short_pn <= next_short_pn;
      phase    <= next_phase;
      mix_cnt  <= next_mix_cnt;
      ustate   <= next_ustate;
      data     <= next_data;
      active   <= next_active;
    end
  end

endmodule

// >>> test/adc_bank_checker.sv
/*
  Port checker for the control bank.
  Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/1ps

module adc_bank_checker #(
  parameter int W = 16
) (
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         reg_wr_en,
  input wire logic         reg_rd_en,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic [7:0]   reg_rdata,
  input wire logic         reg_rd_valid,
  input wire logic [1:0]   power_down,
  input wire logic [1:0]   standby,
  input wire logic [1:0]   digital_reset,
  input wire logic [1:0]   ext_pd_enable,
  input wire logic         dcs_enable,
  input wire logic [2:0]   clk_div_ratio,
  input wire logic         clk_div_tick,
  input wire logic         self_test_enable,
  input wire logic         self_test_init,
  input wire logic [1:0]   pattern_active,
  input wire logic [W-1:0] pattern_data_a
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_rd_answer: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read answer timing wrong");
  chk_rd_hold: assert property (!reg_rd_valid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_pwr_excl: assert property ((power_down & standby) == 2'h0 && (digital_reset & (power_down | standby)) == 2'h0)
    else $error("power modes overlap");
  chk_div_clamp: assert property (clk_div_ratio <= 3'h5)
    else $error("divider code above five");
  chk_div_half: assert property (clk_div_tick && clk_div_ratio == 3'h1 && $stable(clk_div_ratio) |=> !clk_div_tick)
    else $error("divide by two ticked twice");
  chk_div_every: assert property (clk_div_tick && clk_div_ratio == 3'h0 ##1 clk_div_ratio == 3'h0 |-> clk_div_tick)
    else $error("divide by one missed a tick");
  chk_idle_zero: assert property (!pattern_active[0] |-> pattern_data_a == '0)
    else $error("idle pattern not zero");
  chk_reset_gate: assert property (digital_reset[0] |=> !pattern_active[0])
    else $error("pattern active in digital reset");
  // live copies may only move two edges after a transfer write
  chk_xfer_only: assert property ($changed({dcs_enable, clk_div_ratio, self_test_enable, self_test_init,
    ext_pd_enable, power_down}) |-> $past(reg_wr_en, 2) && $past(reg_addr, 2) == 8'hFF && $past(reg_wdata, 2) == 8'h01)
    else $error("live setting moved without transfer");
endmodule

// >>> test/host_model.sv
/*
  Host side of the byte register port.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps

module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  output logic            reg_wr_en = 1'b0,
  output logic            reg_rd_en = 1'b0,
  output logic [7:0]      reg_addr = 8'h00,
  output logic [7:0]      reg_wdata = 8'h00
);
  // idle bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule

// >>> test/tb_top.sv
/*
  Self-checking bench for the control bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps

module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr_en, reg_rd_en, reg_rd_valid, dcs_enable, clk_div_tick, self_test_enable, self_test_init;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0]  power_down, standby, digital_reset, ext_pd_enable, pattern_active;
  logic [2:0]  clk_div_ratio;
  logic [15:0] pattern_data_a, pattern_data_b, prev;
  logic        vv;
  int          mismatches = 0;
  int          n_compared = 0;
  int          k;
  logic [15:0] rst_tab [8] = '{16'h0503, 16'h0880, 16'h0900, 16'h0B00, 16'h0D00, 16'h0E00, 16'hFF00, 16'h1300};
  logic [15:0] u_tab [8] = '{16'h1234, 16'h1234, 16'h5678, 16'h1234, 16'h0000, 16'h0000, 16'h5678, 16'h0000};

  always #4 ref_clk = ~ref_clk;
  adc_control_register_bank #(.W(16)) dut (.*);
  host_model host (.*);

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv, vv);
    chk("rd_valid", 16'(vv), 16'h1);
    chk("rdata", 16'(rv), 16'(e));
  endtask

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic xfer();
    host.wr(8'hFF, 8'h01);
    repeat (2) @(posedge ref_clk);
    step();
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    host.wr(8'h13, 8'hFF);
    host.wr(8'h05, 8'hFF);
    foreach (rst_tab[i]) rdc(rst_tab[i][15:8], rst_tab[i][7:0]);
    chk("ext_pd", 16'(ext_pd_enable), 16'h3);
    host.wr(8'h09, 8'h01);
    host.wr(8'h0E, 8'h05);
    host.wr(8'h0B, 8'h07);
    rdc(8'h09, 8'h01);
    chk("dcs_early", 16'(dcs_enable), 16'h0);
    xfer();
    chk("dcs", 16'(dcs_enable), 16'h1);
    chk("self_test", 16'({self_test_enable, self_test_init}), 16'h3);
    chk("div_clamp", 16'(clk_div_ratio), 16'h5);
    rdc(8'hFF, 8'h00);
    host.wr(8'h0B, 8'h01);
    xfer();
    k = 0;
    repeat (12) begin
      step();
      k += int'(clk_div_tick);
    end
    chk("ticks", 16'(k), 16'h6);
    host.wr(8'h0B, 8'h00);
    host.wr(8'h05, 8'h01);
    host.wr(8'h0D, 8'h01);
    host.wr(8'h05, 8'h02);
    host.wr(8'h0D, 8'h03);
    host.wr(8'h05, 8'h03);
    rdc(8'h0D, 8'h01);
    host.wr(8'h05, 8'h02);
    rdc(8'h0D, 8'h03);
    xfer();
    chk("pat_a", pattern_data_a, 16'h8000);
    chk("pat_b", pattern_data_b, 16'h0000);
    chk("act_ab", 16'(pattern_active), 16'h3);
    host.wr(8'h05, 8'h03);
    for (int c = 0; c < 11; c++) begin
      host.wr(8'h0D, 8'(c));
      xfer();
      prev = pattern_data_a;
      step();
      chk("active", 16'(pattern_active), c == 0 ? 16'h0 : 16'h3);
      if (c >= 1 && c <= 3) chk("const", pattern_data_a, c == 1 ? 16'h8000 : c == 2 ? 16'hFFFF : 16'h0);
      if (c == 4 || c == 7 || c == 9) chk("toggle", prev ^ pattern_data_a, c == 9 ? 16'hAAAA : 16'hFFFF);
      if (c == 5 || c == 6 || c == 10) chk("moving", 16'(prev != pattern_data_a), 16'h1);
    end
    // generator reset bits hold the all-ones seed
    for (int c = 0; c < 2; c++) begin
      host.wr(8'h0D, c == 0 ? 8'h25 : 8'h16);
      xfer();
      step();
      chk("pn_hold", pattern_data_a, 16'hFFFF);
    end
    host.wr(8'h19, 8'h34);
    host.wr(8'h1A, 8'h12);
    host.wr(8'h1B, 8'h78);
    host.wr(8'h1C, 8'h56);
    for (int s = 0; s < 4; s++) begin
      host.wr(8'h0D, {2'(s), 6'h08});
      xfer();
      k = 0;
      while (pattern_data_a !== 16'h1234 && k < 8) begin
        step();
        k++;
      end
      step();
      chk("user_1", pattern_data_a, u_tab[2 * s]);
      step();
      chk("user_2", pattern_data_a, u_tab[2 * s + 1]);
    end
    host.wr(8'h05, 8'h01);
    host.wr(8'h08, 8'h01);
    host.wr(8'h05, 8'h02);
    host.wr(8'h08, 8'h82);
    xfer();
    chk("pwr", 16'({power_down, standby, ext_pd_enable}), 16'h1A);
    host.wr(8'h05, 8'h03);
    host.wr(8'h08, 8'h03);
    xfer();
    step();
    chk("dreset", 16'({digital_reset, pattern_active}), 16'hC);
    host.wr(8'h08, 8'h00);
    xfer();
    chk("run", 16'({power_down, standby, digital_reset}), 16'h0);
    test_done();
  end

  // whole run needs well under 5000 cycles
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule

bind adc_control_register_bank adc_bank_checker #(.W(W)) chk (.*);
